// ===== hdl/wdp_pkg.sv
// Package with the constants and types of the protected watchdog control block.
package wdp_pkg;

    // ------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_CTRL_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COUNTER     = 8'h01;
    localparam logic [ADDR_W-1:0] OFF_INT_STATUS  = 8'h02;
    localparam logic [ADDR_W-1:0] OFF_INT_ENABLE  = 8'h03;
    localparam logic [ADDR_W-1:0] OFF_INT_CLEAR   = 8'h04;

    // ------------------------------------------------------------------
    // Control/status field positions
    // ------------------------------------------------------------------
    localparam int CSR_FLAG_BIT = 0;
    localparam int CSR_INH0_BIT = 1;
    localparam int CSR_EN_BIT   = 2;
    localparam int CSR_INH2_BIT = 3;
    localparam int CSR_RWE_BIT  = 4;
    localparam int CSR_INH4_BIT = 5;
    localparam int CSR_CWE_BIT  = 6;
    localparam int CSR_INH6_BIT = 7;

    // ------------------------------------------------------------------
    // Interrupt status field positions
    // ------------------------------------------------------------------
    localparam int EVT_OVF_BIT      = 0;
    localparam int EVT_CNT_BLK_BIT  = 1;
    localparam int EVT_CTRL_BLK_BIT = 2;
    localparam int EVT_W            = 3;

    // ------------------------------------------------------------------
    // Reset and read values
    // ------------------------------------------------------------------
    localparam logic             INHIBIT_READ_VAL = 1'b1;
    localparam logic [CNT_W-1:0] COUNTER_RST_VAL  = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO       = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 5;
    localparam int TICK_DIV_DEFAULT = 8192;
    localparam int RESET_PULSE_NS   = 80;
    localparam int RESET_PULSE_CYC  = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W        = $clog2(RESET_PULSE_CYC + 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic cnt_we;
        logic reg_we;
        logic wd_en;
        logic rst_flag;
    } wdp_ctrl_t;

    typedef struct packed {
        logic ctrl_blocked;
        logic cnt_blocked;
        logic overflow;
    } wdp_evt_t;

    localparam wdp_ctrl_t CTRL_RST_VAL = '{cnt_we: 1'b0, reg_we: 1'b0, wd_en: 1'b0, rst_flag: 1'b0};
    localparam wdp_evt_t  EVT_RST_VAL  = '{ctrl_blocked: 1'b0, cnt_blocked: 1'b0, overflow: 1'b0};

endpackage

// ===== hdl/wdp_counter.sv
// Eight-bit up counter of the watchdog with software load and overflow pulse.
`timescale 1ns/100ps

module wdp_counter
    import wdp_pkg::*;
#(
    parameter int W = CNT_W
) (
    // Clock and reset
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    // Control
    input  wire logic         tick_in,
    input  wire logic         load_in,
    input  wire logic [W-1:0] load_val_in,
    // Status
    output logic      [W-1:0] count_out,
    output logic              ovf_out
);

    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic         ovf_r;
    logic         ovf_nxt;
    wire          at_top = &count_r;

    // A load in the same cycle as a tick takes precedence and cancels the overflow.
    assign count_nxt = load_in ? load_val_in : (tick_in ? W'(count_r + 1'b1) : count_r);
    assign ovf_nxt   = tick_in && at_top && !load_in;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            count_r <= COUNTER_RST_VAL;
            ovf_r   <= 1'b0;
        end else begin
            count_r <= count_nxt;
            ovf_r   <= ovf_nxt;
        end
    end

    assign count_out = count_r;
    assign ovf_out   = ovf_r;

endmodule

// ===== hdl/wdp_top.sv
// Protected control/status logic, counter and reset generation of the watchdog.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/100ps

module wdp_top
    import wdp_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEFAULT
) (
    // Clock and reset
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [DATA_W-1:0] rdata_out,
    // External reset pin
    input  wire logic              ext_rst_pin_n_in,
    // System outputs
    output logic                   wdt_reset_out,
    output logic                   irq_out,
    output logic                   wd_enable_out
);

    // ------------------------------------------------------------------
    // Local sizes
    // ------------------------------------------------------------------
    // The prescaler keeps at least one bit even for a divide of one.
    localparam int PRE_W = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_DIV - 1);
    localparam logic [RST_CNT_W-1:0] RST_PULSE_LOAD = RST_CNT_W'(RESET_PULSE_CYC);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // A write qualifies a control bit when its partner inhibit bit is written as zero.
    function automatic logic inh_released(input logic [DATA_W-1:0] d, input int pos);
        return ~d[pos];
    endfunction

    // Builds the byte seen on reads of the control/status register.
    function automatic logic [DATA_W-1:0] csr_image(input wdp_ctrl_t c);
        logic [DATA_W-1:0] v;
        v               = READ_ZERO;
        v[CSR_INH6_BIT] = INHIBIT_READ_VAL;
        v[CSR_CWE_BIT]  = c.cnt_we;
        v[CSR_INH4_BIT] = INHIBIT_READ_VAL;
        v[CSR_RWE_BIT]  = c.reg_we;
        v[CSR_INH2_BIT] = INHIBIT_READ_VAL;
        v[CSR_EN_BIT]   = c.wd_en;
        v[CSR_INH0_BIT] = INHIBIT_READ_VAL;
        v[CSR_FLAG_BIT] = c.rst_flag;
        return v;
    endfunction

    // Zero-extends an event vector to the data width.
    function automatic logic [DATA_W-1:0] evt_image(input wdp_evt_t e);
        return {{(DATA_W - EVT_W){1'b0}}, e};
    endfunction

    // Decodes one register slot of the byte-wide register port.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    wdp_ctrl_t              ctrl_r;
    wdp_ctrl_t              ctrl_nxt;
    wdp_evt_t               int_status_r;
    wdp_evt_t               int_status_nxt;
    wdp_evt_t               int_enable_r;
    wdp_evt_t               int_enable_nxt;
    logic [PRE_W-1:0]       pre_cnt_r;
    logic [PRE_W-1:0]       pre_cnt_nxt;
    logic [RST_CNT_W-1:0]   rst_cnt_r;
    logic [RST_CNT_W-1:0]   rst_cnt_nxt;
    logic                   wdt_reset_r;
    logic                   wdt_reset_nxt;
    logic                   irq_r;
    logic                   irq_nxt;
    logic [DATA_W-1:0]      rdata_r;
    logic [DATA_W-1:0]      rdata_nxt;
    logic                   pin_sync1_r;
    logic                   pin_sync2_r;

    // ------------------------------------------------------------------
    // External reset pin synchroniser
    // ------------------------------------------------------------------
    // Both stages reset to the idle level of the pin, so no false clear follows reset.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_sync1_r <= 1'b1;
        end else begin
            pin_sync1_r <= ext_rst_pin_n_in;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pin_sync2_r <= 1'b1;
        end else begin
            pin_sync2_r <= pin_sync1_r;
        end
    end

    // Only the second stage is read, so a settling first stage never reaches the flag.
    wire pin_reset_active = ~pin_sync2_r;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Unmapped addresses select nothing: their writes are dropped and their reads give zero.
    wire sel_ctrl     = addr_hit(addr_in, OFF_CTRL_STATUS);
    wire sel_counter  = addr_hit(addr_in, OFF_COUNTER);
    wire sel_int_stat = addr_hit(addr_in, OFF_INT_STATUS);
    wire sel_int_en   = addr_hit(addr_in, OFF_INT_ENABLE);
    wire sel_int_clr  = addr_hit(addr_in, OFF_INT_CLEAR);

    wire wr_ctrl      = wr_in && sel_ctrl;
    wire wr_counter   = wr_in && sel_counter;
    wire wr_int_en    = wr_in && sel_int_en;
    wire wr_int_clr   = wr_in && sel_int_clr;

    // ------------------------------------------------------------------
    // Protected control/status write qualification
    // ------------------------------------------------------------------
    // The register write enable itself is only guarded by its own inhibit bit, so that
    // software can open the register after reset.
    wire upd_rwe  = wr_ctrl && inh_released(wdata_in, CSR_INH4_BIT);
    wire upd_cwe  = wr_ctrl && ctrl_r.reg_we
                    && inh_released(wdata_in, CSR_INH6_BIT);
    wire upd_en   = wr_ctrl && ctrl_r.reg_we
                    && inh_released(wdata_in, CSR_INH2_BIT);
    wire upd_flag = wr_ctrl && ctrl_r.reg_we
                    && inh_released(wdata_in, CSR_INH0_BIT);

    // Software can only clear the flag; a one in the flag position is ignored.
    wire sw_flag_clear = upd_flag && !wdata_in[CSR_FLAG_BIT];
    wire flag_clear    = sw_flag_clear || pin_reset_active;

    // A locked register still passes bit 4; a write that keeps bit 4 guarded or tries to
    // open any other guarded bit is reported as a blocked attempt.
    wire rwe_guarded        = !inh_released(wdata_in, CSR_INH4_BIT);
    wire locked_try         = inh_released(wdata_in, CSR_INH6_BIT)
                              || inh_released(wdata_in, CSR_INH2_BIT)
                              || inh_released(wdata_in, CSR_INH0_BIT);
    wire ctrl_write_blocked = wr_ctrl && !ctrl_r.reg_we && (rwe_guarded || locked_try);

    // ------------------------------------------------------------------
    // Counter write gating
    // ------------------------------------------------------------------
    // A refused load leaves the count untouched and only raises the blocked-load event.
    wire cnt_load        = wr_counter && ctrl_r.cnt_we;
    wire cnt_write_block = wr_counter && !ctrl_r.cnt_we;

    // ------------------------------------------------------------------
    // Prescaler and counter
    // ------------------------------------------------------------------
    wire              pre_wrap = (pre_cnt_r == PRE_LAST);
    wire              cnt_tick = ctrl_r.wd_en && pre_wrap;
    wire [CNT_W-1:0]  count_val;
    wire              cnt_ovf;

    // The prescaler restarts on a load so the loaded value gets a full tick period.
    wire              pre_restart = !ctrl_r.wd_en || cnt_load || pre_wrap;

    assign pre_cnt_nxt = pre_restart ? '0 : PRE_W'(pre_cnt_r + 1'b1);

    // The count wraps through zero and keeps running; its overflow pulse and its read value are used.
    wdp_counter #(
        .W           (CNT_W)
    ) wdp_counter_inst (
        .clk_in      (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .tick_in     (cnt_tick),
        .load_in     (cnt_load),
        .load_val_in (wdata_in[CNT_W-1:0]),
        .count_out   (count_val),
        .ovf_out     (cnt_ovf)
    );

    // ------------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (upd_rwe) begin
            ctrl_nxt.reg_we = wdata_in[CSR_RWE_BIT];
        end
        // Bit 4 written now unlocks the other bits only from the next write on.
        if (upd_cwe) begin
            ctrl_nxt.cnt_we = wdata_in[CSR_CWE_BIT];
        end
        if (upd_en) begin
            ctrl_nxt.wd_en = wdata_in[CSR_EN_BIT];
        end
        if (flag_clear) begin
            ctrl_nxt.rst_flag = 1'b0;
        end
        // An overflow in the same cycle as any clear leaves the flag set.
        if (cnt_ovf) begin
            ctrl_nxt.rst_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // System reset pulse
    // ------------------------------------------------------------------
    wire rst_cnt_busy = (rst_cnt_r != '0);

    // A new overflow during the pulse reloads the count and so stretches the pulse.
    assign rst_cnt_nxt = cnt_ovf ? RST_PULSE_LOAD
                         : (rst_cnt_busy ? RST_CNT_W'(rst_cnt_r - 1'b1) : rst_cnt_r);

    // The pulse goes out only; it does not clear this block, so the flag outlives it.
    assign wdt_reset_nxt = (rst_cnt_nxt != '0);

    // ------------------------------------------------------------------
    // Interrupt status, enable and clear
    // ------------------------------------------------------------------
    wdp_evt_t evt_now;
    wdp_evt_t clr_mask;

    assign evt_now.overflow     = cnt_ovf;
    assign evt_now.cnt_blocked  = cnt_write_block;
    assign evt_now.ctrl_blocked = ctrl_write_blocked;
    assign clr_mask             = wr_int_clr ? wdp_evt_t'(wdata_in[EVT_W-1:0]) : EVT_RST_VAL;

    // New events win over a clear in the same cycle; each one bit written clears its status bit.
    assign int_status_nxt = (int_status_r & ~clr_mask) | evt_now;
    assign int_enable_nxt = wr_int_en ? wdp_evt_t'(wdata_in[EVT_W-1:0]) : int_enable_r;

    // Built from next values so the output rises on the same edge as the status bit.
    assign irq_nxt = |(int_status_nxt & int_enable_nxt);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [DATA_W-1:0] img_ctrl  = csr_image(ctrl_r);
    wire [DATA_W-1:0] img_count = DATA_W'(count_val);
    wire [DATA_W-1:0] img_stat  = evt_image(int_status_r);
    wire [DATA_W-1:0] img_en    = evt_image(int_enable_r);

    // The write-only clear register reads as zero.
    wire [DATA_W-1:0] rd_mux    = sel_ctrl     ? img_ctrl
                                : sel_counter  ? img_count
                                : sel_int_stat ? img_stat
                                : sel_int_en   ? img_en
                                : READ_ZERO;

    assign rdata_nxt = rd_in ? rd_mux : READ_ZERO;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    // Reset leaves the watchdog off and the register locked.
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl_r <= CTRL_RST_VAL;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rst_cnt_r <= '0;
        end else begin
            rst_cnt_r <= rst_cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            int_status_r <= EVT_RST_VAL;
        end else begin
            int_status_r <= int_status_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            int_enable_r <= EVT_RST_VAL;
        end else begin
            int_enable_r <= int_enable_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            wdt_reset_r <= 1'b0;
        end else begin
            wdt_reset_r <= wdt_reset_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_r <= READ_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every output leaves straight from a register.
    assign rdata_out     = rdata_r;
    assign wdt_reset_out = wdt_reset_r;
    assign irq_out       = irq_r;
    assign wd_enable_out = ctrl_r.wd_en;

endmodule

// ===== tb/wdp_properties.sv
// Concurrent properties of the protected watchdog control block.
`timescale 1ns/100ps

module wdp_properties
    import wdp_pkg::*;
(
    // Clock and reset
    input wire logic              sys_clk_in,
    input wire logic              rst_n_in,
    // Register port
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [DATA_W-1:0] rdata_out,
    // Pins
    input wire logic              ext_rst_pin_n_in,
    input wire logic              wdt_reset_out,
    input wire logic              irq_out,
    input wire logic              wd_enable_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    wire ctrl_wr = wr_in && (addr_in == OFF_CTRL_STATUS);
    wire clr_all = wr_in && (addr_in == OFF_INT_CLEAR) && (wdata_in == 8'h07);

    property p_rd_idle;
        !$past(rd_in) |-> rdata_out == READ_ZERO;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rst_len;
        $rose(wdt_reset_out) |-> wdt_reset_out[*8] ##1 wdt_reset_out[*8];
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse too short");
    property p_inh_guard;
        ctrl_wr && wdata_in[CSR_INH2_BIT] |=> $stable(wd_enable_out);
    endproperty
    a_inh_guard: assert property (p_inh_guard) else $error("guarded enable changed");
    property p_en_hold;
        !ctrl_wr |=> $stable(wd_enable_out);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed without write");
    property p_unmapped;
        rd_in && (addr_in > OFF_INT_CLEAR) |=> rdata_out == READ_ZERO;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_inh_read;
        rd_in && (addr_in == OFF_CTRL_STATUS) |=> (rdata_out & 8'hAA) == 8'hAA;
    endproperty
    a_inh_read: assert property (p_inh_read) else $error("inhibit bits not one");
    property p_clr_irq;
        clr_all |=> ##1 (!irq_out || wdt_reset_out);
    endproperty
    a_clr_irq: assert property (p_clr_irq) else $error("interrupt stays after clear");
    property p_out_rst;
        disable iff (1'b0)
        !rst_n_in |=> !wdt_reset_out && !irq_out && !wd_enable_out && rdata_out == READ_ZERO;
    endproperty
    a_out_rst: assert property (p_out_rst) else $error("outputs active after reset");

    c_ovf: cover property ($rose(wdt_reset_out));
    c_irq: cover property ($rose(irq_out));
    c_en: cover property (ctrl_wr && !wdata_in[CSR_INH2_BIT] ##1 $rose(wd_enable_out));
endmodule

bind wdp_top wdp_properties wdp_properties_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_rst_pin_n_in(ext_rst_pin_n_in),
    .wdt_reset_out(wdt_reset_out), .irq_out(irq_out), .wd_enable_out(wd_enable_out)
);

// ===== tb/tb_wdp_top.sv
// Self-checking testbench of the protected watchdog control block.
`timescale 1ns/100ps

module tb_wdp_top
    import wdp_pkg::*;
;
    localparam int TDIV = 4;
    localparam logic [ADDR_W-1:0] CS = OFF_CTRL_STATUS;
    localparam logic [ADDR_W-1:0] CN = OFF_COUNTER;

    logic              sys_clk_in = 1'b0;
    logic              rst_n_in   = 1'b0;
    logic [ADDR_W-1:0] addr       = 8'h00;
    logic [DATA_W-1:0] wdata      = 8'h00;
    logic              wr         = 1'b0;
    logic              rd         = 1'b0;
    logic              pin_n      = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic              wdt_rst;
    logic              irq;
    logic              wd_en;
    int                error_cnt   = 0;
    int                comparisons = 0;

    wdp_top #(.TICK_DIV(TDIV)) wdp_top_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .ext_rst_pin_n_in(pin_n),
        .wdt_reset_out(wdt_rst), .irq_out(irq), .wd_enable_out(wd_en)
    );

    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic check_byte(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected byte at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected bit at %0t: got %b, expected %b", $time, got, exp);
        end
    endtask

    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        check_byte(rdata, exp);
    endtask

    task automatic check_irq(input logic exp);
        repeat (2) @(posedge sys_clk_in);
        #1;
        check_bit(irq, exp);
    endtask

    // Waits a bounded time for the watchdog reset pulse to start.
    task automatic wait_rst();
        int n;
        n = 0;
        while (wdt_rst !== 1'b1 && n < 200) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        check_bit(wdt_rst, 1'b1);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        #20000;
        error_cnt++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        bus_rd(CS, 8'hAA);
        bus_rd(CN, 8'h00);
        bus_rd(OFF_INT_STATUS, 8'h00);
        bus_wr(8'h10, 8'hFF);
        bus_rd(8'h10, 8'h00);
        bus_wr(CS, 8'hC4);
        bus_rd(CS, 8'hAA);
        bus_rd(OFF_INT_STATUS, 8'h04);
        bus_wr(CN, 8'h55);
        bus_rd(CN, 8'h00);
        bus_rd(OFF_INT_STATUS, 8'h06);
        bus_wr(CS, 8'h30);
        bus_rd(CS, 8'hAA);
        bus_wr(CS, 8'h10);
        bus_rd(CS, 8'hBA);
        bus_wr(CS, 8'hD0);
        bus_rd(CS, 8'hBA);
        bus_wr(CS, 8'h50);
        bus_rd(CS, 8'hFA);
        bus_wr(CN, 8'hFE);
        bus_rd(CN, 8'hFE);
        bus_wr(CS, 8'h5C);
        bus_rd(CS, 8'hFA);
        check_bit(wd_en, 1'b0);
        bus_wr(CS, 8'h54);
        bus_rd(CS, 8'hFE);
        check_bit(wd_en, 1'b1);
        wait_rst();
        bus_rd(CS, 8'hFF);
        repeat (14) @(posedge sys_clk_in);
        #1;
        check_bit(wdt_rst, 1'b0);
        bus_rd(OFF_INT_STATUS, 8'h07);
        bus_wr(CS, 8'h53);
        bus_rd(CS, 8'hFB);
        check_bit(wd_en, 1'b0);
        bus_wr(CS, 8'h51);
        bus_rd(CS, 8'hFB);
        bus_wr(CS, 8'h50);
        bus_rd(CS, 8'hFA);
        bus_wr(OFF_INT_ENABLE, 8'h00);
        check_irq(1'b0);
        bus_wr(OFF_INT_ENABLE, 8'h01);
        check_irq(1'b1);
        bus_wr(OFF_INT_CLEAR, 8'h07);
        check_irq(1'b0);
        bus_rd(OFF_INT_STATUS, 8'h00);
        bus_rd(OFF_INT_CLEAR, 8'h00);
        bus_rd(OFF_INT_ENABLE, 8'h01);
        bus_wr(CN, 8'hFF);
        bus_wr(CS, 8'h54);
        wait_rst();
        check_irq(1'b1);
        bus_wr(CS, 8'h53);
        bus_rd(CS, 8'hFB);
        @(posedge sys_clk_in);
        pin_n <= 1'b0;
        repeat (4) @(posedge sys_clk_in);
        pin_n <= 1'b1;
        repeat (20) @(posedge sys_clk_in);
        bus_rd(CS, 8'hFA);
        bus_wr(OFF_INT_CLEAR, 8'h07);
        check_irq(1'b0);
        bus_wr(CS, 8'h00);
        bus_rd(CS, 8'hAA);
        bus_wr(CS, 8'h44);
        bus_rd(CS, 8'hAA);
        give_verdict();
    end
endmodule
